// *** jrp_link_param_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jrp_cfg.svh"

module jrp_link_param_regs #(
  parameter int LANES  = 8,   // Logical lanes.
  parameter int LANE_W = 32,  // Bits per lane word.
  parameter int CONVS  = 4,   // Converters.
  parameter int SPC    = 4    // Samples per converter.
) (
  input  wire logic         clk,           // System clock.
  input  wire logic         sys_rst,       // Synchronous reset.
  input  wire logic         ce,            // Clock enable.
  input  wire jrp_pkg::jrp_reg_addr_t reg_addr,  // Register address.
  input  wire jrp_pkg::jrp_byte_t     reg_wdata, // Write data.
  input  wire logic         reg_wr,        // Write strobe.
  input  wire logic         reg_rd,        // Read strobe.
  output jrp_pkg::jrp_byte_t          reg_rdata, // Read data.
  output logic              reg_rvalid,    // Read data valid.
  input  wire logic [LANES*LANE_W-1:0] lane_in,  // Deserialized.
  output logic [LANES*LANE_W-1:0]      lane_out, // After inversion.
  input  wire logic         cfg_start,     // Lane 0 alignment starts.
  input  wire logic         cfg_end,       // Lane 0 alignment ends.
  input  wire logic         cfg_octet_valid, // Config octet strobe.
  input  wire jrp_pkg::jrp_oct_idx_t cfg_octet_index, // Position.
  input  wire jrp_pkg::jrp_byte_t    cfg_octet,       // Value.
  input  wire logic [CONVS*SPC*16-1:0] samples, // Receiver samples.
  input  wire logic         samples_valid, // Samples strobe.
  output logic              link_setup_ok  // Setup byte correct.
);
  import jrp_pkg::*;

  jrp_cfg_if cfg ();

  jrp_byte_t  test_ctrl;
  jrp_byte_t  ref_low;
  jrp_byte_t  ref_high;
  jrp_byte_t  link_setup;
  jrp_byte_t  invert_mask;
  jrp_byte_t  next_test_ctrl;
  jrp_byte_t  next_ref_low;
  jrp_byte_t  next_ref_high;
  jrp_byte_t  next_link_setup;
  jrp_byte_t  next_invert_mask;
  jrp_byte_t  next_rdata;
  logic       next_rvalid;
  logic       check_fail;
  logic       unmapped;
  logic [LANES*LANE_W-1:0] next_lane_out;

  // Captures the lane 0 configuration fields.
  jrp_cfg_capture u_capture (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .cfg_start   (cfg_start),
    .cfg_end     (cfg_end),
    .octet_valid (cfg_octet_valid),
    .octet_index (cfg_octet_index),
    .octet       (cfg_octet),
    .cfg         (cfg.source)
  );

  // Runs the short sample check against the assembled reference.
  jrp_sample_check #(
    .CONVS (CONVS),
    .SPC   (SPC)
  ) u_check (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .ce            (ce),
    .enable        (test_ctrl[`JRP_TEST_EN_BIT]),
    .clear         (test_ctrl[`JRP_TEST_CLR_BIT]),
    .conv_sel      (test_ctrl[`JRP_CONV_SEL_LSB +: 2]),
    .samp_sel      (test_ctrl[`JRP_SAMP_SEL_LSB +: 2]),
    .ref_sample    ({ref_high, ref_low}),
    .samples       (samples),
    .samples_valid (samples_valid),
    .fail          (check_fail)
  );

  // Writable registers; writes to read-only or unmapped bytes are
  // dropped without any indication, as the port has no error path.
  always_comb
  begin
    next_test_ctrl   = test_ctrl;
    next_ref_low     = ref_low;
    next_ref_high    = ref_high;
    next_link_setup  = link_setup;
    next_invert_mask = invert_mask;
    if (reg_wr)
    begin
      case (reg_addr)
        `JRP_ADDR_TEST_CTRL:
          next_test_ctrl = reg_wdata & `JRP_MASK_TEST_CTRL;
        `JRP_ADDR_REF_LOW:  next_ref_low     = reg_wdata;
        `JRP_ADDR_REF_HIGH: next_ref_high    = reg_wdata;
        `JRP_ADDR_SETUP:    next_link_setup  = reg_wdata;
        `JRP_ADDR_INVERT:   next_invert_mask = reg_wdata;
        default:            next_link_setup  = link_setup;
      endcase
    end
  end

  // Writable bytes; a low clock enable freezes them along with the rest.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      test_ctrl   <= `JRP_RST_BYTE;
      ref_low     <= `JRP_RST_BYTE;
      ref_high    <= `JRP_RST_BYTE;
      link_setup  <= `JRP_RST_BYTE;
      invert_mask <= `JRP_RST_BYTE;
    end
    else if (ce)
    begin
      test_ctrl   <= next_test_ctrl;
      ref_low     <= next_ref_low;
      ref_high    <= next_ref_high;
      link_setup  <= next_link_setup;
      invert_mask <= next_invert_mask;
    end
  end

  assign link_setup_ok = (link_setup == `JRP_SETUP_GOOD);

  // Read path; answers one cycle after the strobe, unmapped reads
  // return zero so software never sees stale bus data.
  always_comb
  begin
    next_rvalid = reg_rd;
    next_rdata  = reg_rdata;
    unmapped    = 1'b0;
    if (reg_rd)
    begin
      case (reg_addr)
        `JRP_ADDR_TEST_CTRL: next_rdata = test_ctrl;
        `JRP_ADDR_REF_LOW:   next_rdata = ref_low;
        `JRP_ADDR_REF_HIGH:  next_rdata = ref_high;
        `JRP_ADDR_RESULT:
        begin
          next_rdata = `JRP_RST_BYTE;
          next_rdata[`JRP_RESULT_FAIL_BIT] = check_fail;
        end
        `JRP_ADDR_SETUP:     next_rdata = link_setup;
        `JRP_ADDR_INVERT:    next_rdata = invert_mask;
        `JRP_ADDR_DEV_NUM:   next_rdata = cfg.dev_num;
        `JRP_ADDR_ADJ_BANK:  next_rdata = cfg.adj_bank;
        `JRP_ADDR_LANE_ID:   next_rdata = cfg.lane_id;
        `JRP_ADDR_SCR_LANES: next_rdata = cfg.scr_lanes;
        `JRP_ADDR_OCTETS:    next_rdata = cfg.octets;
        default:
        begin
          next_rdata = `JRP_RST_BYTE;
          unmapped   = 1'b1;
        end
      endcase
    end
  end

  // The answer is registered, so read data stands until the next read.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= `JRP_RST_BYTE;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // per-lane inversion.
  // The inverted data costs one register stage of latency, traded for
  // a clean timing path from the deserializer.
  always_comb
  begin
    for (int l = 0; l < LANES; l++)
    begin
      next_lane_out[l*LANE_W +: LANE_W] =
        lane_in[l*LANE_W +: LANE_W] ^ {LANE_W{invert_mask[l]}};
    end
  end

  // Output stage for the lane data.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lane_out <= '0;
    else if (ce)
      lane_out <= next_lane_out;
  end

  // Register checks. Every read check looks one cycle after the strobe,
  // when the registered answer is settled; the captured fields may move
  // in that cycle, so the expected value is taken at the strobe.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ref_high_write: assert property (
    ce && reg_wr && reg_addr == `JRP_ADDR_REF_HIGH
    |=> ref_high == $past(reg_wdata))
    else $error("Reference high byte not stored.");

  a_ref_low_write: assert property (
    ce && reg_wr && reg_addr == `JRP_ADDR_REF_LOW
    |=> ref_low == $past(reg_wdata))
    else $error("Reference low byte not stored.");

  a_result_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_RESULT
    |=> reg_rvalid && reg_rdata == {7'h00, $past(check_fail)})
    else $error("Result byte read back wrong.");

  a_lane_passthru: assert property (
    ce && invert_mask == 8'h00 |=> lane_out == $past(lane_in))
    else $error("Uninverted lanes were altered.");

  a_lane_flip: assert property (
    ce && invert_mask == 8'hff |=> lane_out == ~$past(lane_in))
    else $error("Masked lanes were not inverted.");

  a_dev_num_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_DEV_NUM
    |=> reg_rdata == $past(cfg.dev_num))
    else $error("Device number read back wrong.");

  a_lane_cnt_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_SCR_LANES
    |=> reg_rdata[4:0] == $past(cfg.scr_lanes[4:0]))
    else $error("Lane count read back wrong.");

  a_octets_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_OCTETS
    |=> reg_rdata == $past(cfg.octets))
    else $error("Octet count read back wrong.");

  a_ctrl_write: assert property (
    ce && reg_wr && reg_addr == `JRP_ADDR_TEST_CTRL
    |=> test_ctrl[5:2] == $past(reg_wdata[5:2]) && test_ctrl[7:6] == 2'h0)
    else $error("Check control fields not stored.");

  a_unmapped_zero: assert property (
    ce && reg_rd && unmapped |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned nonzero.");

  a_bank_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_ADJ_BANK
    |=> reg_rdata == $past(cfg.adj_bank))
    else $error("Adjust and bank byte read back wrong.");

  a_lane_id_read: assert property (
    ce && reg_rd && reg_addr == `JRP_ADDR_LANE_ID
    |=> reg_rdata[4:0] == $past(cfg.lane_id[4:0]) && !reg_rdata[7])
    else $error("Lane identifier read back wrong.");

  a_mask_write: assert property (
    ce && reg_wr && reg_addr == `JRP_ADDR_INVERT
    |=> invert_mask == $past(reg_wdata))
    else $error("Lane invert mask not stored.");

  a_read_answer: assert property (
    ce |=> reg_rvalid == $past(reg_rd))
    else $error("Read answer not one cycle after the strobe.");

  c_setup_good: cover property (ce && link_setup_ok);
  c_check_pass_read: cover property (
    ce && reg_rd && reg_addr == `JRP_ADDR_RESULT && !check_fail);
  c_cfg_seen: cover property (ce && cfg.dev_num != 8'h00);
  c_all_lanes_flipped: cover property (ce && invert_mask == 8'hff);

endmodule // jrp_link_param_regs

`default_nettype wire

// *** jrp_cfg.svh ***
`ifndef JRP_CFG_SVH
`define JRP_CFG_SVH

// Register byte addresses.
`define JRP_ADDR_TEST_CTRL  12'h32c
`define JRP_ADDR_REF_LOW    12'h32d
`define JRP_ADDR_REF_HIGH   12'h32e
`define JRP_ADDR_RESULT     12'h32f
`define JRP_ADDR_SETUP      12'h333
`define JRP_ADDR_INVERT     12'h334
`define JRP_ADDR_DEV_NUM    12'h400
`define JRP_ADDR_ADJ_BANK   12'h401
`define JRP_ADDR_LANE_ID    12'h402
`define JRP_ADDR_SCR_LANES  12'h403
`define JRP_ADDR_OCTETS     12'h404

// Field positions in the check control and result bytes.
`define JRP_TEST_EN_BIT     0
`define JRP_TEST_CLR_BIT    1
`define JRP_CONV_SEL_LSB    2
`define JRP_SAMP_SEL_LSB    4
`define JRP_RESULT_FAIL_BIT 0

// Reset value, writable-bit and captured-field masks and the required setup value.
`define JRP_RST_BYTE        8'h00
`define JRP_MASK_TEST_CTRL  8'h3f
`define JRP_MASK_LANE_ID    8'h7f
`define JRP_MASK_SCR_LANES  8'h9f
`define JRP_SETUP_GOOD      8'h01

// Octet positions inside the lane 0 configuration data.
`define JRP_OCT_DEV_NUM     4'h0
`define JRP_OCT_ADJ_BANK    4'h1
`define JRP_OCT_LANE_ID     4'h2
`define JRP_OCT_SCR_LANES   4'h3
`define JRP_OCT_OCTETS      4'h4

// Converter sample width.
`define JRP_SAMPLE_W        16

`endif

// *** jrp_pkg.sv ***
`default_nettype none

package jrp_pkg;

  typedef logic [11:0] jrp_reg_addr_t;
  typedef logic [7:0]  jrp_byte_t;
  typedef logic [3:0]  jrp_oct_idx_t;

  // Capture states, one-hot.
  typedef enum logic [1:0] {
    JRP_CAP_IDLE = 2'b01,
    JRP_CAP_RECV = 2'b10
  } jrp_cap_state_t;

endpackage

`default_nettype wire

// *** jrp_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Captured link configuration bytes, passed from capture to registers.
interface jrp_cfg_if;
  logic [7:0] dev_num;
  logic [7:0] adj_bank;
  logic [7:0] lane_id;
  logic [7:0] scr_lanes;
  logic [7:0] octets;

  modport source (output dev_num, adj_bank, lane_id, scr_lanes, octets);
  modport sink   (input  dev_num, adj_bank, lane_id, scr_lanes, octets);
endinterface

`default_nettype wire

// *** jrp_cfg_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jrp_cfg.svh"

module jrp_cfg_capture (
  input  wire logic           clk,          // System clock.
  input  wire logic           sys_rst,      // Synchronous reset.
  input  wire logic           ce,           // Clock enable.
  input  wire logic           cfg_start,    // Alignment data begins.
  input  wire logic           cfg_end,      // Alignment data ends.
  input  wire logic           octet_valid,  // Config octet strobe.
  input  wire jrp_pkg::jrp_oct_idx_t octet_index, // Octet position.
  input  wire jrp_pkg::jrp_byte_t    octet,       // Octet value.
  jrp_cfg_if.source           cfg           // Captured fields.
);
  import jrp_pkg::*;

  jrp_cap_state_t state;
  jrp_cap_state_t next_state;
  jrp_byte_t      next_dev_num;
  jrp_byte_t      next_adj_bank;
  jrp_byte_t      next_lane_id;
  jrp_byte_t      next_scr_lanes;
  jrp_byte_t      next_octets;

  // Octets outside an alignment window are ignored, so idle data
  // carrying look-alike bytes cannot disturb the stored fields.
  // capture from lane 0.
  always_comb
  begin
    next_state     = state;
    next_dev_num   = cfg.dev_num;
    next_adj_bank  = cfg.adj_bank;
    next_lane_id   = cfg.lane_id;
    next_scr_lanes = cfg.scr_lanes;
    next_octets    = cfg.octets;
    case (state)
      JRP_CAP_IDLE:
      begin
        if (cfg_start)
          next_state = JRP_CAP_RECV;
      end
      JRP_CAP_RECV:
      begin
        if (octet_valid)
        begin
          case (octet_index)
            `JRP_OCT_DEV_NUM:   next_dev_num  = octet;
            `JRP_OCT_ADJ_BANK:  next_adj_bank = octet;
            `JRP_OCT_LANE_ID:
              next_lane_id = octet & `JRP_MASK_LANE_ID;
            `JRP_OCT_SCR_LANES:
              next_scr_lanes = octet & `JRP_MASK_SCR_LANES;
            `JRP_OCT_OCTETS:    next_octets   = octet;
            default:            next_octets   = cfg.octets;
          endcase
        end
        if (cfg_end)
          next_state = JRP_CAP_IDLE;
      end
      default: next_state = JRP_CAP_IDLE;
    endcase
  end

  // Fields stay zero until the first configuration data arrives.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state         <= JRP_CAP_IDLE;
      cfg.dev_num   <= `JRP_RST_BYTE;
      cfg.adj_bank  <= `JRP_RST_BYTE;
      cfg.lane_id   <= `JRP_RST_BYTE;
      cfg.scr_lanes <= `JRP_RST_BYTE;
      cfg.octets    <= `JRP_RST_BYTE;
    end
    else if (ce)
    begin
      state         <= next_state;
      cfg.dev_num   <= next_dev_num;
      cfg.adj_bank  <= next_adj_bank;
      cfg.lane_id   <= next_lane_id;
      cfg.scr_lanes <= next_scr_lanes;
      cfg.octets    <= next_octets;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_idle_fields_held: assert property (
    ce && state == JRP_CAP_IDLE
    |=> $stable(cfg.dev_num) && $stable(cfg.adj_bank)
        && $stable(cfg.lane_id) && $stable(cfg.scr_lanes)
        && $stable(cfg.octets))
    else $error("Fields changed outside an alignment window.");

  a_dev_num_capture: assert property (
    ce && state == JRP_CAP_RECV && octet_valid
    && octet_index == `JRP_OCT_DEV_NUM
    |=> cfg.dev_num == $past(octet))
    else $error("Device number octet not captured.");

endmodule // jrp_cfg_capture

`default_nettype wire

// *** jrp_sample_check.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jrp_cfg.svh"

module jrp_sample_check #(
  parameter int CONVS = 4,  // Converters.
  parameter int SPC   = 4   // Samples per converter.
) (
  input  wire logic         clk,        // System clock.
  input  wire logic         sys_rst,    // Synchronous reset.
  input  wire logic         ce,         // Clock enable.
  input  wire logic         enable,     // Check enable.
  input  wire logic         clear,      // Result clear.
  input  wire logic [1:0]   conv_sel,   // Converter select.
  input  wire logic [1:0]   samp_sel,   // Sample select.
  input  wire logic [15:0]  ref_sample, // Expected sample.
  input  wire logic [CONVS*SPC*16-1:0] samples, // Receiver output.
  input  wire logic         samples_valid, // Samples strobe.
  output logic              fail        // Mismatch seen.
);
  import jrp_pkg::*;

  logic [15:0] picked;
  logic        mismatch;
  logic        next_fail;

  always_comb
  begin
    picked   = samples[(int'(conv_sel) * SPC + int'(samp_sel))
                       * `JRP_SAMPLE_W +: `JRP_SAMPLE_W];
    mismatch = enable && samples_valid && (picked != ref_sample);
    next_fail = fail;
    if (clear)
      next_fail = 1'b0;
    // A mismatch in the clearing cycle is kept, never lost.
    if (mismatch)
      next_fail = 1'b1;
  end

  // The flag is sticky; only the clear bit or a reset drops it.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fail <= 1'b0;
    else if (ce)
      fail <= next_fail;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fail_on_miss: assert property (
    ce && mismatch |=> fail)
    else $error("Mismatch did not raise the fail flag.");

  a_clear_on_match: assert property (
    ce && clear && !mismatch |=> !fail)
    else $error("Clear without mismatch left the flag set.");

  c_check_fails: cover property (ce && mismatch);

endmodule // jrp_sample_check

`default_nettype wire

// *** jrp_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Transmitter side: sends lane 0 alignment octets in one window.
module jrp_tx_model (
  input  wire logic             clk,             // System clock.
  output logic                  cfg_start,       // Window opens.
  output logic                  cfg_end,         // Window closes.
  output logic                  cfg_octet_valid, // Octet strobe.
  output jrp_pkg::jrp_oct_idx_t cfg_octet_index, // Octet position.
  output jrp_pkg::jrp_byte_t    cfg_octet        // Octet value.
);
  import jrp_pkg::*;

  // Idle lines never hold the last octet, so stale data cannot pass.
  initial
  begin
    cfg_start = 1'b0;
    cfg_end = 1'b0;
    cfg_octet_valid = 1'b0;
    cfg_octet_index = 4'h9;
    cfg_octet = 8'h3c;
  end

  // After a window the octet lines change once, to the inverted octet and next index.
  task automatic go_idle();
    cfg_octet_valid <= 1'b0;
    cfg_end <= 1'b0;
    cfg_octet <= ~cfg_octet;
    cfg_octet_index <= cfg_octet_index + 4'h1;
  endtask

  // sends caller octets as given; the caller zeros the adjust fields.
  task automatic send(input logic [39:0] v);
    @(posedge clk);
    cfg_start <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      cfg_start <= 1'b0;
      cfg_octet_valid <= 1'b1;
      cfg_octet_index <= 4'(i);
      cfg_octet <= v[8*i +: 8];
      cfg_end <= (i == 4);
    end
    @(posedge clk);
    go_idle();
  endtask

  // An octet outside any window, which the receiver must ignore.
  task automatic stray(input jrp_oct_idx_t idx, input jrp_byte_t val);
    @(posedge clk);
    cfg_octet_valid <= 1'b1;
    cfg_octet_index <= idx;
    cfg_octet <= val;
    @(posedge clk);
    go_idle();
  endtask
endmodule // jrp_tx_model

`default_nettype wire

// *** jrp_link_param_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jrp_cfg.svh"

module jrp_link_param_regs_tb_top;
  import jrp_pkg::*;

  logic          clk, sys_rst, ce, reg_wr, reg_rd, reg_rvalid;
  logic          link_setup_ok, samples_valid;
  logic          cfg_start, cfg_end, cfg_octet_valid;
  jrp_oct_idx_t  cfg_octet_index;
  jrp_byte_t     cfg_octet, reg_wdata, reg_rdata;
  jrp_reg_addr_t reg_addr;
  logic [255:0]  lane_in, lane_out, samples;
  logic [7:0]    expq[$];
  logic [15:0]   lf = 16'h1bad;
  int            n_fail = 0;
  int            n_compared = 0;
  int            cycles = 0;

  jrp_link_param_regs jrp_link_param_regs_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lane_in(lane_in), .lane_out(lane_out), .cfg_start(cfg_start),
    .cfg_end(cfg_end), .cfg_octet_valid(cfg_octet_valid),
    .cfg_octet_index(cfg_octet_index), .cfg_octet(cfg_octet),
    .samples(samples), .samples_valid(samples_valid),
    .link_setup_ok(link_setup_ok));

  jrp_tx_model jrp_tx_model_i (
    .clk(clk), .cfg_start(cfg_start), .cfg_end(cfg_end),
    .cfg_octet_valid(cfg_octet_valid),
    .cfg_octet_index(cfg_octet_index), .cfg_octet(cfg_octet));

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pseudo-random source, a fixed-seed shift register.
  function automatic logic [15:0] rnd16();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  function automatic logic [255:0] rnd256();
    logic [255:0] r;
    for (int i = 0; i < 16; i++)
      r[16*i +: 16] = rnd16();
    return r;
  endfunction

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input jrp_reg_addr_t a, input jrp_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // The expected answer is noted before the read is issued.
  task automatic rd(input jrp_reg_addr_t a, input jrp_byte_t e);
    expq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic pulse(input logic [255:0] s);
    @(posedge clk);
    samples <= s;
    samples_valid <= 1'b1;
    @(posedge clk);
    samples_valid <= 1'b0;
  endtask

  // Each read answer is matched against the oldest note.
  always @(posedge clk)
  begin
    if (reg_rvalid === 1'b1)
      check(reg_rdata, expq.size() > 0 ? expq.pop_front() : 8'hxx);
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    jrp_reg_addr_t amap[12];
    int            cnt[3];
    logic [15:0]   r, d, b, sl;
    logic [7:0]    m, ctl;
    logic [255:0]  ex, sm;
    amap = '{`JRP_ADDR_TEST_CTRL, `JRP_ADDR_REF_LOW, `JRP_ADDR_REF_HIGH,
             `JRP_ADDR_RESULT, `JRP_ADDR_SETUP, `JRP_ADDR_INVERT,
             `JRP_ADDR_DEV_NUM, `JRP_ADDR_ADJ_BANK, `JRP_ADDR_LANE_ID,
             `JRP_ADDR_SCR_LANES, `JRP_ADDR_OCTETS, 12'h3ff};
    cnt = '{0, 1, 3};
    sys_rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    lane_in = '0;
    samples = '0;
    samples_valid = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Every register, and an unmapped place, reads zero after reset.
    foreach (amap[i])
      rd(amap[i], 8'h00);
    check(link_setup_ok, 1'b0);
    wr(`JRP_ADDR_TEST_CTRL, 8'hff);
    rd(`JRP_ADDR_TEST_CTRL, 8'h3f);
    wr(`JRP_ADDR_SETUP, `JRP_SETUP_GOOD);
    #1 check(link_setup_ok, 1'b1);
    rd(`JRP_ADDR_SETUP, 8'h01);
    wr(`JRP_ADDR_DEV_NUM, 8'h77);
    rd(`JRP_ADDR_DEV_NUM, 8'h00);
    // A write while the clock enable is low must not land.
    @(posedge clk);
    ce <= 1'b0;
    wr(`JRP_ADDR_REF_LOW, 8'h12);
    ce <= 1'b1;
    rd(`JRP_ADDR_REF_LOW, 8'h00);
    r = rnd16();
    wr(`JRP_ADDR_REF_HIGH, r[15:8]);
    wr(`JRP_ADDR_REF_LOW, r[7:0]);
    rd(`JRP_ADDR_REF_HIGH, r[15:8]);
    rd(`JRP_ADDR_REF_LOW, r[7:0]);
    // Lane inversion with several masks.
    for (int n = 0; n < 3; n++)
    begin
      // The first mask flips every lane, the others are random.
      m = (n == 0) ? 8'hff : 8'(rnd16());
      wr(`JRP_ADDR_INVERT, m);
      lane_in <= rnd256();
      repeat (2) @(posedge clk);
      #1;
      for (int l = 0; l < 8; l++)
        ex[32*l +: 32] = lane_in[32*l +: 32] ^ {32{m[l]}};
      check(lane_out, ex);
      rd(`JRP_ADDR_INVERT, m);
    end
    // Link parameters for lane and octet counts of 0, 1 and 3.
    foreach (cnt[k])
    begin
      d = rnd16();
      b = rnd16();
      jrp_tx_model_i.send({8'(cnt[k]), 3'b111, 5'(cnt[k]),
                           3'b100, b[8:4], 4'h0, b[3:0], d[7:0]});
      jrp_tx_model_i.stray(4'h0, ~d[7:0]);
      rd(`JRP_ADDR_DEV_NUM, d[7:0]);
      rd(`JRP_ADDR_ADJ_BANK, {4'h0, b[3:0]});
      rd(`JRP_ADDR_LANE_ID, {3'b000, b[8:4]});
      rd(`JRP_ADDR_SCR_LANES, {3'b100, 5'(cnt[k])});
      rd(`JRP_ADDR_OCTETS, 8'(cnt[k]));
    end
    // With the check disabled a mismatch leaves the flag clear.
    wr(`JRP_ADDR_TEST_CTRL, 8'h00);
    pulse(~samples);
    rd(`JRP_ADDR_RESULT, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ctl = {2'b00, 2'(3 - i), 2'(i), 2'b01};
      sl = (i[0]) ? 16'h0001 : 16'h8000;
      wr(`JRP_ADDR_TEST_CTRL, ctl | 8'h02);
      wr(`JRP_ADDR_TEST_CTRL, ctl);
      sm = rnd256();
      sm[(i*4 + 3 - i)*16 +: 16] = r;
      pulse(sm);
      rd(`JRP_ADDR_RESULT, 8'h00);
      sm[(i*4 + 3 - i)*16 +: 16] = r ^ sl;
      pulse(sm);
      rd(`JRP_ADDR_RESULT, 8'h01);
    end
    wr(`JRP_ADDR_TEST_CTRL, 8'h02);
    rd(`JRP_ADDR_RESULT, 8'h00);
    repeat (4) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    wrap_up();
  end
endmodule // jrp_link_param_regs_tb_top

`default_nettype wire
